// [rtl/status_led_indicator.sv]
// front-panel link/activity and run indicator driver
// Functional notes
// - port link/activity indicator dark while that port has no link
// - linked port without traffic lights its indicator steadily
// - linked port with frames blinks its indicator
// - run indicator off in INIT
// - run indicator single flash in PREOP
// - run indicator regular flashing in SAFEOP
// - run indicator steady green in OP
// - run indicator fast flicker in BOOTSTRAP
// - fieldbus mode, switch moved: steady orange until reset
// - ethernet mode, switch moved: steady red until reset
// - invalid switch at power-on: alternate red/green until valid
`timescale 1ns/1ps
module status_led_indicator
    import status_led_pkg::*;
#(
    parameter int unsigned PORTS = 2,
    parameter int unsigned TICK_DIV = TICK_CYCLES
)(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [PORTS-1:0] link_up,
    input wire logic [PORTS-1:0] frame_seen,
    input wire logic [2:0] slave_state,
    input wire logic [SW_W-1:0] mode_switch,
    input wire logic fieldbus_mode,
    output logic [PORTS-1:0] link_led,
    output logic run_green,
    output logic run_red
);
    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    logic [15:0] div_r;
    logic tick_r;

    always_ff @(posedge clock) begin
        if (sys_rst || div_r == 16'(TICK_DIV - 1)) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= (div_r == 16'(TICK_DIV - 1));
        end
    end

    // ------------------------------------------------------------
    // per-port indicators
    // ------------------------------------------------------------
    for (genvar i = 0; i < PORTS; i++) begin : g_port
        link_act_led u_port (
            .clock(clock),
            .sys_rst(sys_rst),
            .tick(tick_r),
            .link_up(link_up[i]),
            .frame_seen(frame_seen[i]),
            .led(link_led[i])
        );
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] st_s1_r, st_s2_r;
    logic [SW_W-1:0] sw_s1_r, sw_s2_r;
    logic [1:0] mode_sync_r;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_s1_r <= SM_INIT;
            st_s2_r <= SM_INIT;
            sw_s1_r <= '0;
            sw_s2_r <= '0;
            mode_sync_r <= 2'h0;
        end else begin
            st_s1_r <= slave_state;
            st_s2_r <= st_s1_r;
            sw_s1_r <= mode_switch;
            sw_s2_r <= sw_s1_r;
            mode_sync_r <= {mode_sync_r[0], fieldbus_mode};
        end
    end

    // ------------------------------------------------------------
    // pattern generators
    // ------------------------------------------------------------
    logic [9:0] flk_r, fls_r, sgl_r, alt_r;
    logic flk_ph_r, fls_ph_r, alt_ph_r;

    // distinct periods: flicker 100 ms, flash 400 ms, single 1 s
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flk_r <= 10'h000;
            flk_ph_r <= 1'b0;
        end else if (tick_r) begin
            if (flk_r >= FLICKER_HALF_MS - 10'h001) begin
                flk_r <= 10'h000;
                flk_ph_r <= ~flk_ph_r;
            end else begin
                flk_r <= flk_r + 10'h001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fls_r <= 10'h000;
            fls_ph_r <= 1'b0;
        end else if (tick_r) begin
            if (fls_r >= FLASH_HALF_MS - 10'h001) begin
                fls_r <= 10'h000;
                fls_ph_r <= ~fls_ph_r;
            end else begin
                fls_r <= fls_r + 10'h001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sgl_r <= 10'h000;
        end else if (tick_r) begin
            if (sgl_r >= SINGLE_PERIOD_MS - 10'h001) begin
                sgl_r <= 10'h000;
            end else begin
                sgl_r <= sgl_r + 10'h001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            alt_r <= 10'h000;
            alt_ph_r <= 1'b0;
        end else if (tick_r) begin
            if (alt_r >= ALT_HALF_MS - 10'h001) begin
                alt_r <= 10'h000;
                alt_ph_r <= ~alt_ph_r;
            end else begin
                alt_r <= alt_r + 10'h001;
            end
        end
    end

    logic single_on;
    assign single_on = (sgl_r < SINGLE_ON_MS);

    // ------------------------------------------------------------
    // switch supervision
    // ------------------------------------------------------------
    // position captured a few cycles after reset release, once synced
    logic [1:0] settle_r;
    logic armed_r;
    logic [SW_W-1:0] sw_ref_r;
    logic sw_valid;
    run_state_t run_r;

    assign sw_valid = (32'(sw_s2_r) <= SW_VALID_MAX);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            settle_r <= 2'h0;
            armed_r <= 1'b0;
            sw_ref_r <= '0;
        end else if (!armed_r) begin
            settle_r <= settle_r + 2'h1;
            if (settle_r == 2'h3) begin
                armed_r <= 1'b1;
                sw_ref_r <= sw_s2_r;
            end
        end else if (run_r == RUN_BAD_SWITCH && sw_valid) begin
            sw_ref_r <= sw_s2_r;
        end
    end

    // faults latch until reset; bad switch clears once valid
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run_r <= RUN_NORMAL;
        end else begin
            case (run_r)
                RUN_NORMAL: begin
                    if (armed_r && sw_s2_r != sw_ref_r) begin
                        run_r <= mode_sync_r[1] ? RUN_FB_FAULT : RUN_ETH_FAULT;
                    end else if (!armed_r && settle_r == 2'h3 && !sw_valid) begin
                        run_r <= RUN_BAD_SWITCH;
                    end
                end
                RUN_BAD_SWITCH: begin
                    if (sw_valid) begin
                        run_r <= RUN_NORMAL;
                    end
                end
                RUN_FB_FAULT: run_r <= RUN_FB_FAULT;
                RUN_ETH_FAULT: run_r <= RUN_ETH_FAULT;
                default: run_r <= RUN_NORMAL;
            endcase
        end
    end

    // ------------------------------------------------------------
    // run indicator (orange = red + green)
    // ------------------------------------------------------------
    logic green_nxt;

    always_comb begin
        case (st_s2_r)
            SM_INIT: green_nxt = 1'b0;
            SM_PREOP: green_nxt = single_on;
            SM_SAFEOP: green_nxt = fls_ph_r;
            SM_OP: green_nxt = 1'b1;
            SM_BOOT: green_nxt = flk_ph_r;
            default: green_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run_green <= 1'b0;
            run_red <= 1'b0;
        end else begin
            case (run_r)
                RUN_FB_FAULT: begin
                    run_green <= 1'b1;
                    run_red <= 1'b1;
                end
                RUN_ETH_FAULT: begin
                    run_green <= 1'b0;
                    run_red <= 1'b1;
                end
                RUN_BAD_SWITCH: begin
                    run_green <= alt_ph_r;
                    run_red <= ~alt_ph_r;
                end
                default: begin
                    run_green <= green_nxt;
                    run_red <= 1'b0;
                end
            endcase
        end
    end

    init_off_a: assert property (@(posedge clock) disable iff (sys_rst)
        run_r == RUN_NORMAL && st_s2_r == SM_INIT |=> !run_green && !run_red)
        else $error("run lit in init");
    op_steady_a: assert property (@(posedge clock) disable iff (sys_rst)
        run_r == RUN_NORMAL && st_s2_r == SM_OP |=> run_green && !run_red)
        else $error("run not steady in op");
    preop_single_a: assert property (@(posedge clock) disable iff (sys_rst)
        run_r == RUN_NORMAL && st_s2_r == SM_PREOP |=> run_green == $past(single_on))
        else $error("preop pattern wrong");
    safeop_flash_a: assert property (@(posedge clock) disable iff (sys_rst)
        run_r == RUN_NORMAL && st_s2_r == SM_SAFEOP |=> run_green == $past(fls_ph_r))
        else $error("safeop pattern wrong");
    boot_flicker_a: assert property (@(posedge clock) disable iff (sys_rst)
        run_r == RUN_NORMAL && st_s2_r == SM_BOOT |=> run_green == $past(flk_ph_r))
        else $error("bootstrap pattern wrong");
    fb_orange_a: assert property (@(posedge clock) disable iff (sys_rst)
        run_r == RUN_FB_FAULT |=> run_green && run_red && run_r == RUN_FB_FAULT)
        else $error("fieldbus fault not orange");
    eth_red_a: assert property (@(posedge clock) disable iff (sys_rst)
        run_r == RUN_ETH_FAULT |=> !run_green && run_red && run_r == RUN_ETH_FAULT)
        else $error("ethernet fault not red");
    bad_alt_a: assert property (@(posedge clock) disable iff (sys_rst)
        run_r == RUN_BAD_SWITCH |=> run_green != run_red)
        else $error("bad switch not alternating");
    move_detect_a: assert property (@(posedge clock) disable iff (sys_rst)
        run_r == RUN_NORMAL && armed_r && sw_s2_r != sw_ref_r
        |=> run_r == RUN_FB_FAULT || run_r == RUN_ETH_FAULT)
        else $error("switch move missed");
    flash_period_a: assert property (@(posedge clock) disable iff (sys_rst)
        tick_r && fls_r == FLASH_HALF_MS - 10'h001 |=> fls_ph_r != $past(fls_ph_r))
        else $error("flash half period wrong");
endmodule

// [rtl/status_led_pkg.sv]
// constants and types for the front-panel indicator logic
package status_led_pkg;
    // ------------------------------------------------------------
    // clock and blink timing
    // ------------------------------------------------------------
    localparam int unsigned CLOCK_HZ = 20000000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = (CLOCK_HZ / 1000000) * TICK_US;
    // periods in ticks (1 ms each)
    localparam logic [9:0] FLICKER_HALF_MS = 10'h032;
    localparam logic [9:0] FLASH_HALF_MS = 10'h0c8;
    localparam logic [9:0] SINGLE_ON_MS = 10'h0c8;
    localparam logic [9:0] SINGLE_PERIOD_MS = 10'h3e8;
    localparam logic [9:0] ACT_HALF_MS = 10'h032;
    localparam logic [9:0] ALT_HALF_MS = 10'h0c8;
    localparam logic [9:0] ACT_HOLD_MS = 10'h064;

    // ------------------------------------------------------------
    // slave state encoding and switch
    // ------------------------------------------------------------
    localparam logic [2:0] SM_INIT = 3'h1;
    localparam logic [2:0] SM_PREOP = 3'h2;
    localparam logic [2:0] SM_BOOT = 3'h3;
    localparam logic [2:0] SM_SAFEOP = 3'h4;
    localparam logic [2:0] SM_OP = 3'h0;
    localparam int unsigned SW_W = 4;
    localparam int unsigned SW_VALID_MAX = 9;

    typedef enum logic [3:0] {
        RUN_NORMAL = 4'h1,
        RUN_FB_FAULT = 4'h2,
        RUN_ETH_FAULT = 4'h4,
        RUN_BAD_SWITCH = 4'h8
    } run_state_t;
endpackage

// [rtl/link_act_led.sv]
// one port link/activity indicator driver
`timescale 1ns/1ps
module link_act_led
    import status_led_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic link_up,
    input wire logic frame_seen,
    output logic led
);
    logic [1:0] link_sync_r;
    logic [1:0] act_sync_r;
    logic [9:0] hold_r;
    logic [9:0] blink_r;
    logic phase_r;

    // pin inputs cross into the clock domain
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link_sync_r <= 2'h0;
            act_sync_r <= 2'h0;
        end else begin
            link_sync_r <= {link_sync_r[0], link_up};
            act_sync_r <= {act_sync_r[0], frame_seen};
        end
    end

    // stretch short frames so a blink is visible
    always_ff @(posedge clock) begin
        if (sys_rst || !link_sync_r[1]) begin
            hold_r <= 10'h000;
        end else if (act_sync_r[1]) begin
            hold_r <= ACT_HOLD_MS;
        end else if (tick && hold_r != 10'h000) begin
            hold_r <= hold_r - 10'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            blink_r <= 10'h000;
            phase_r <= 1'b0;
        end else if (tick) begin
            if (blink_r >= ACT_HALF_MS - 10'h001) begin
                blink_r <= 10'h000;
                phase_r <= ~phase_r;
            end else begin
                blink_r <= blink_r + 10'h001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || !link_sync_r[1]) begin
            led <= 1'b0;
        end else if (hold_r != 10'h000) begin
            led <= phase_r;
        end else begin
            led <= 1'b1;
        end
    end

    dark_nolink_a: assert property (@(posedge clock) disable iff (sys_rst)
        !link_sync_r[1] |=> !led) else $error("led lit without link");
    steady_link_a: assert property (@(posedge clock) disable iff (sys_rst)
        link_sync_r[1] && hold_r == 10'h000 |=> led)
        else $error("linked idle led not on");
endmodule

// [sim/led_observer.sv]
// operator model: times the lit and dark runs of one indicator
`timescale 1ns/1ps
module led_observer (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic led,
    output logic [31:0] last_hi,
    output logic [31:0] last_lo,
    output logic [31:0] edges
);
    logic prev_r;
    logic [31:0] run_r;

    // ------------------------------------------------------------
    // run length timing
    // ------------------------------------------------------------
    // an operator only tells patterns apart by on and off times
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prev_r <= led;
            run_r <= 32'h1;
            last_hi <= 32'h0;
            last_lo <= 32'h0;
            edges <= 32'h0;
        end else if (led !== prev_r) begin
            prev_r <= led;
            run_r <= 32'h1;
            edges <= edges + 32'h1;
            if (prev_r) begin
                last_hi <= run_r;
            end else begin
                last_lo <= run_r;
            end
        end else begin
            run_r <= run_r + 32'h1;
        end
    end
endmodule

// [sim/testbench.sv]
// self-checking bench for the front-panel indicator driver
`timescale 1ns/1ps
module testbench
    import status_led_pkg::*;
;
    // short tick so that one ms lasts TD clocks
    localparam int TD = 4;
    localparam int LIMIT = 40000;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] link_up = 2'h0;
    logic [1:0] frame_seen = 2'h0;
    logic [2:0] slave_state = SM_INIT;
    logic [3:0] mode_switch = 4'h2;
    logic fieldbus_mode = 1'b1;
    logic [1:0] link_led;
    logic run_green;
    logic run_red;
    logic [31:0] g_hi, g_lo, g_ed, r_hi, r_lo, r_ed, l_hi, l_lo, l_ed, e;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;

    status_led_indicator #(.PORTS(2), .TICK_DIV(TD)) i_status_led_indicator (
        .clock(clock), .sys_rst(sys_rst), .link_up(link_up), .frame_seen(frame_seen),
        .slave_state(slave_state), .mode_switch(mode_switch), .fieldbus_mode(fieldbus_mode),
        .link_led(link_led), .run_green(run_green), .run_red(run_red));
    led_observer obs_grn (.clock(clock), .sys_rst(sys_rst), .led(run_green),
        .last_hi(g_hi), .last_lo(g_lo), .edges(g_ed));
    led_observer obs_red (.clock(clock), .sys_rst(sys_rst), .led(run_red),
        .last_hi(r_hi), .last_lo(r_lo), .edges(r_ed));
    led_observer obs_lnk (.clock(clock), .sys_rst(sys_rst), .led(link_led[0]),
        .last_hi(l_hi), .last_lo(l_lo), .edges(l_ed));

    // ------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #25 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask

    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // blink runs may land one tick off depending on the free-running tick phase
    task automatic check_near(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if ($isunknown(got) || got + TD < exp || got > exp + TD) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reset_pulse();
        sys_rst = 1'b1;
        cycles(16);
        check_eq({29'h0, link_led, run_green}, 32'h0);
        check_eq({31'h0, run_red}, 32'h0);
        sys_rst = 1'b0;
        cycles(8);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_link();
        link_up = 2'h0;
        frame_seen = 2'h3;
        cycles(600);
        check_eq({30'h0, link_led}, 32'h0);
        link_up = 2'h3;
        frame_seen = 2'h0;
        cycles(600);
        e = l_ed;
        cycles(400);
        check_eq(l_ed, e);
        check_eq({30'h0, link_led}, 32'h3);
        frame_seen = 2'h1;
        cycles(1200);
        check_near(l_hi, 50 * TD);
        check_near(l_lo, 50 * TD);
        check_eq({31'h0, link_led[1]}, 32'h1);
        frame_seen = 2'h0;
        cycles(800);
        check_eq({31'h0, link_led[0]}, 32'h1);
        $display("test link done");
    endtask

    task automatic run_steady(input logic [2:0] st, input logic v);
        slave_state = st;
        cycles(40);
        e = g_ed;
        cycles(1000);
        check_eq(g_ed, e);
        check_eq({30'h0, run_red, run_green}, {31'h0, v});
    endtask

    task automatic run_blink(input logic [2:0] st, input int hi, input int lo);
        slave_state = st;
        cycles(2 * (hi + lo) + 40);
        check_near(g_hi, hi);
        check_near(g_lo, lo);
        check_eq({31'h0, run_red}, 32'h0);
    endtask

    task automatic t_fault(input logic fb);
        fieldbus_mode = fb;
        mode_switch = 4'h2;
        reset_pulse();
        mode_switch = 4'h5;
        cycles(10);
        check_eq({30'h0, run_red, run_green}, {30'h0, 1'b1, fb});
        mode_switch = 4'h2;
        cycles(1000);
        check_eq({30'h0, run_red, run_green}, {30'h0, 1'b1, fb});
        $display("test switch fault done");
    endtask

    task automatic t_badsw();
        slave_state = SM_OP;
        mode_switch = 4'hc;
        reset_pulse();
        cycles(2000);
        check_near(r_hi, 200 * TD);
        check_near(r_lo, 200 * TD);
        check_eq({31'h0, run_green}, {31'h0, ~run_red});
        // another invalid position keeps the alternating pattern going
        mode_switch = 4'he;
        cycles(20);
        e = r_ed;
        cycles(1000);
        check_eq(r_ed - e, 32'h1);
        check_eq({31'h0, run_green}, {31'h0, ~run_red});
        mode_switch = 4'h3;
        cycles(20);
        e = r_ed;
        cycles(500);
        check_eq(r_ed, e);
        check_eq({30'h0, run_red, run_green}, 32'h1);
        $display("test bad switch done");
    endtask

    initial begin
        reset_pulse();
        t_link();
        run_steady(SM_INIT, 1'b0);
        run_steady(3'h5, 1'b0);
        run_steady(SM_OP, 1'b1);
        run_blink(SM_PREOP, 200 * TD, 800 * TD);
        run_blink(SM_SAFEOP, 200 * TD, 200 * TD);
        run_blink(SM_BOOT, 50 * TD, 50 * TD);
        $display("test run patterns done");
        t_fault(1'b1);
        t_fault(1'b0);
        t_badsw();
        give_verdict();
    end
endmodule
